/* File: src/phyrm_pkg.sv */
// constants, types and register map of the transceiver reset and management register bank
// What this block does
// - device runs its own power-up settle sequence once the external reset pin is released.
// - hardware reset restores every register default and recaptures the strap inputs.
// - writing one to bit 15 of basic_control starts a software reset.
// - software reset completes about 1 us after the bit is written.
// - software reset restores register defaults but keeps the captured strap values.
// - address 05h returns partner base page or next page, per current exchange.
// - basic_control bits 15..7 are reset to collision test; bits 6..0 reserved.
// - basic_status reports abilities in 15..11 and status flags in bits 6..0.
// - identifier registers return organisation id, six-bit model and four-bit revision.
// - partner base page mirrors the advertisement field layout.
// - next_page_transmit holds next page, message page, ack two, toggle, code.
// - bits follow read-write, read-only, self-clear, clear-on-read, fixed, latched-low types.
package phyrm_pkg;

  // ********************************************
  // timing
  // ********************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int HW_RESET_MIN_NS = 1000;
  localparam int HW_RESET_MIN_CYC = (HW_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SW_RESET_NS = 1000;
  localparam int SW_RESET_CYC = (SW_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MDIO_QUIET_NS = 3000;
  localparam int MDIO_QUIET_CYC = (MDIO_QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SW_CNT_W = 6;
  localparam logic [SW_CNT_W-1:0] SW_CNT_LAST = SW_CNT_W'(SW_RESET_CYC - 1);
  localparam logic [1:0] POR_SETTLE_LAST = 2'h3;

  // ********************************************
  // register offsets
  // ********************************************
  localparam logic [4:0] ADDR_BASIC_CONTROL = 5'h00;
  localparam logic [4:0] ADDR_BASIC_STATUS = 5'h01;
  localparam logic [4:0] ADDR_IDENTIFIER_HIGH = 5'h02;
  localparam logic [4:0] ADDR_IDENTIFIER_LOW = 5'h03;
  localparam logic [4:0] ADDR_AUTONEG_ADVERTISE = 5'h04;
  localparam logic [4:0] ADDR_PARTNER_ABILITY = 5'h05;
  localparam logic [4:0] ADDR_AUTONEG_EXPANSION = 5'h06;
  localparam logic [4:0] ADDR_NEXT_PAGE_TRANSMIT = 5'h07;
  localparam logic [4:0] ADDR_PHY_SUMMARY_STATUS = 5'h10;
  localparam logic [4:0] ADDR_FALSE_CARRIER_COUNTER = 5'h14;
  localparam logic [4:0] ADDR_RECEIVE_ERROR_COUNTER = 5'h15;
  localparam logic [4:0] ADDR_CODING_SUBLAYER_CONFIG = 5'h16;
  localparam logic [4:0] ADDR_REDUCED_IF_BYPASS = 5'h17;
  localparam logic [4:0] ADDR_LED_DIRECT_CONTROL = 5'h18;
  localparam logic [4:0] ADDR_PHY_CONTROL = 5'h19;
  localparam logic [4:0] ADDR_TEN_BASE_STATUS_CONTROL = 5'h1A;
  localparam logic [4:0] ADDR_TEST_AND_SELFTEST_EXT = 5'h1B;
  localparam logic [4:0] ADDR_ENERGY_DETECT_CONTROL = 5'h1D;
  localparam int EXT_RW_NUM = 7;

  // ********************************************
  // field positions
  // ********************************************
  localparam int BC_RESET = 15;
  localparam int BC_LOOPBACK = 14;
  localparam int BC_SPEED = 13;
  localparam int BC_AN_ENABLE = 12;
  localparam int BC_POWER_DOWN = 11;
  localparam int BC_ISOLATE = 10;
  localparam int BC_RESTART_AN = 9;
  localparam int BC_DUPLEX = 8;
  localparam int BC_COL_TEST = 7;
  localparam int BS_PREAMBLE_SUPP = 6;
  localparam int BS_AN_COMPLETE = 5;
  localparam int BS_REMOTE_FAULT = 4;
  localparam int BS_AN_ABILITY = 3;
  localparam int BS_LINK = 2;
  localparam int BS_JABBER = 1;
  localparam int BS_EXT_CAP = 0;
  localparam int PHYCTL_ADDR_W = 5;
  localparam int CNT_W = 8;

  // ********************************************
  // reset values and fixed contents
  // ********************************************
  localparam logic [4:0] BS_ABILITIES = 5'h0F; // no T4; TX full/half, 10 full/half
  localparam logic [15:0] ADV_RESET = 16'h01E1;
  localparam logic [15:0] NP_TX_RESET = 16'h2001;
  localparam logic [15:0] EXT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;
  localparam logic [21:0] OUI_VALUE = 22'h0A5A5A; // arbitrary
  localparam logic [5:0] MODEL_NUMBER = 6'h15; // arbitrary
  localparam logic [3:0] MODEL_REVISION = 4'h1; // arbitrary

  // ********************************************
  // management frame
  // ********************************************
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [3:0] HDR_LAST = 4'hC;
  localparam logic [3:0] DATA_LAST = 4'hF;

  typedef enum logic [2:0] {
    MDIO_IDLE = 3'b000,
    MDIO_HDR = 3'b001,
    MDIO_TA = 3'b010,
    MDIO_WDATA = 3'b011,
    MDIO_RDATA = 3'b100
  } phyrm_mdio_st_t;

endpackage

/* File: src/phyrm_reg_if.sv */
// register access carrier between the management frame engine and the register bank
`timescale 1ns/1ps
interface phyrm_reg_if;
  logic [4:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  modport master (output addr, output wdata, output wr, output rd, input rdata);
  modport slave (input addr, input wdata, input wr, input rd, output rdata);
endinterface

/* File: src/phyrm_sync.sv */
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module phyrm_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

/* File: src/phyrm_mdio.sv */
// serial management frame engine: decodes frames and drives register reads and writes
`timescale 1ns/1ps
module phyrm_mdio
  import phyrm_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_n,
  input wire logic [4:0] phy_addr,
  phyrm_reg_if.master bus
);
  logic mdc_s;
  logic mdio_s;
  logic mdc_d_r;
  logic prev_r;
  logic is_rd_r;
  logic [3:0] cnt_r;
  logic [12:0] hdr_r;
  logic [15:0] sh_r;
  logic [15:0] rhold_r;
  logic [12:0] hdr_nxt;
  logic mdc_rise;
  phyrm_mdio_st_t st_r;

  phyrm_sync #(.W(2)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .d({mdc, mdio_i}),
    .q({mdc_s, mdio_s})
  );

  // edge of the management clock, data is taken on the rising edge
  assign mdc_rise = mdc_s & ~mdc_d_r;
  assign hdr_nxt = {hdr_r[11:0], mdio_s};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mdc_d_r <= 1'b0;
    end else begin
      mdc_d_r <= mdc_s;
    end
  end

  // read data is caught in the cycle of the read strobe, before clear-on-read acts
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rhold_r <= 16'h0000;
    end else if (bus.rd) begin
      rhold_r <= bus.rdata;
    end
  end

  // frame state machine; preamble may be suppressed, a one then zero starts a frame
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= MDIO_IDLE;
      prev_r <= 1'b0;
      is_rd_r <= 1'b0;
      cnt_r <= 4'h0;
      hdr_r <= 13'h0000;
      sh_r <= 16'h0000;
      mdio_o <= 1'b1;
      mdio_oe_n <= 1'b1;
      bus.addr <= 5'h00;
      bus.wdata <= 16'h0000;
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
    end else begin
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      if (mdc_rise) begin
        case (st_r)
          MDIO_IDLE: begin
            prev_r <= mdio_s;
            cnt_r <= 4'h0;
            if (prev_r && !mdio_s) begin
              st_r <= MDIO_HDR;
            end
          end
          MDIO_HDR: begin
            hdr_r <= hdr_nxt;
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == HDR_LAST) begin
              cnt_r <= 4'h0;
              bus.addr <= hdr_nxt[4:0];
              prev_r <= 1'b0;
              if (!hdr_nxt[12] || hdr_nxt[9:5] != phy_addr) begin
                st_r <= MDIO_IDLE;
              end else if (hdr_nxt[11:10] == OP_READ) begin
                st_r <= MDIO_TA;
                is_rd_r <= 1'b1;
                bus.rd <= 1'b1;
              end else if (hdr_nxt[11:10] == OP_WRITE) begin
                st_r <= MDIO_TA;
                is_rd_r <= 1'b0;
              end else begin
                st_r <= MDIO_IDLE;
              end
            end
          end
          MDIO_TA: begin
            cnt_r <= 4'h1;
            if (cnt_r == 4'h0) begin
              if (is_rd_r) begin
                mdio_oe_n <= 1'b0; // drive the second turnaround bit low
                mdio_o <= 1'b0;
              end
            end else begin
              cnt_r <= 4'h0;
              if (is_rd_r) begin
                mdio_o <= rhold_r[15];
                sh_r <= {rhold_r[14:0], 1'b0};
                st_r <= MDIO_RDATA;
              end else begin
                st_r <= MDIO_WDATA;
              end
            end
          end
          MDIO_WDATA: begin
            sh_r <= {sh_r[14:0], mdio_s};
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == DATA_LAST) begin
              bus.wdata <= {sh_r[14:0], mdio_s};
              bus.wr <= 1'b1;
              st_r <= MDIO_IDLE;
            end
          end
          MDIO_RDATA: begin
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == DATA_LAST) begin
              mdio_oe_n <= 1'b1;
              mdio_o <= 1'b1;
              st_r <= MDIO_IDLE;
            end else begin
              mdio_o <= sh_r[15];
              sh_r <= {sh_r[14:0], 1'b0};
            end
          end
          default: begin
            st_r <= MDIO_IDLE;
            mdio_oe_n <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule

/* File: src/phyrm_top.sv */
// management register bank with power-on, hardware and software reset control
`timescale 1ns/1ps
module phyrm_top
  import phyrm_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_n,
  input wire logic [4:0] strap_phy_addr,
  input wire logic strap_an_enable,
  input wire logic strap_speed100,
  input wire logic strap_full_duplex,
  input wire logic stat_link_up,
  input wire logic stat_an_complete,
  input wire logic stat_remote_fault,
  input wire logic stat_jabber,
  input wire logic stat_page_rx,
  input wire logic stat_next_page_sel,
  input wire logic stat_lp_np_able,
  input wire logic stat_lp_an_able,
  input wire logic stat_speed10,
  input wire logic stat_mdix,
  input wire logic stat_polarity,
  input wire logic [15:0] lp_base_page,
  input wire logic [15:0] lp_next_page,
  input wire logic false_carrier_evt,
  input wire logic rx_error_evt,
  output logic ctl_loopback,
  output logic ctl_speed100,
  output logic ctl_an_enable,
  output logic ctl_power_down,
  output logic ctl_isolate,
  output logic ctl_restart_an,
  output logic ctl_full_duplex,
  output logic ctl_col_test,
  output logic [15:0] adv_word,
  output logic [15:0] np_tx_word,
  output logic [4:0] phy_addr,
  output logic sw_reset_busy,
  output logic dev_ready
);
  // ********************************************
  // declarations
  // ********************************************
  phyrm_reg_if bus ();
  logic [7:0] strap_s;
  logic [1:0] por_cnt_r;
  logic strap_cap;
  logic [SW_CNT_W-1:0] sw_cnt_r;
  logic sw_done;
  logic load_defaults;
  logic st_an_en_r;
  logic st_speed_r;
  logic st_duplex_r;
  logic an_cmp_d_r;
  logic link_ll_r;
  logic rf_lh_r;
  logic jab_lh_r;
  logic page_rx_r;
  logic fc_latch_r;
  logic rxe_latch_r;
  logic [CNT_W-1:0] fc_cnt_r;
  logic [CNT_W-1:0] rxe_cnt_r;
  logic [15:0] ext_r [EXT_RW_NUM];
  logic wr_ok;
  logic rd_ok;
  logic rd_of_status;
  logic rd_of_expansion;
  logic rd_of_summary;
  logic rd_of_fc;
  logic rd_of_rxe;
  logic bc_wr;
  logic [15:0] rdata_nxt;
  logic ext_hit;
  logic [2:0] ext_idx;

  // ********************************************
  // strap capture and reset sequencing
  // ********************************************
  phyrm_sync #(.W(8)) u_strap_sync (
    .clk(clk),
    .resetn(resetn),
    .d({strap_phy_addr, strap_an_enable, strap_speed100, strap_full_duplex}),
    .q(strap_s)
  );

  // internal power-up sequence: after release, wait for straps to settle, then run
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      por_cnt_r <= 2'h0;
      dev_ready <= 1'b0;
    end else if (!dev_ready) begin
      por_cnt_r <= por_cnt_r + 2'h1;
      if (por_cnt_r == POR_SETTLE_LAST) begin
        dev_ready <= 1'b1;
      end
    end
  end
  assign strap_cap = !dev_ready && por_cnt_r == POR_SETTLE_LAST;

  // straps are caught only after power-up or the reset pin, never by software reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phy_addr <= 5'h00;
      st_an_en_r <= 1'b0;
      st_speed_r <= 1'b0;
      st_duplex_r <= 1'b0;
    end else if (strap_cap) begin
      {phy_addr, st_an_en_r, st_speed_r, st_duplex_r} <= strap_s;
    end
  end

  // register writes and reads are taken only once the device runs
  assign wr_ok = bus.wr && dev_ready;
  assign rd_ok = bus.rd && dev_ready;
  assign bc_wr = wr_ok && bus.addr == ADDR_BASIC_CONTROL;

  // software reset timer, started by bit 15 of basic_control
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sw_reset_busy <= 1'b0;
      sw_cnt_r <= '0;
    end else if (sw_reset_busy) begin
      sw_cnt_r <= sw_cnt_r + SW_CNT_W'(1);
      if (sw_cnt_r == SW_CNT_LAST) begin
        sw_reset_busy <= 1'b0;
      end
    end else if (bc_wr && bus.wdata[BC_RESET]) begin
      sw_reset_busy <= 1'b1;
      sw_cnt_r <= '0;
    end
  end
  assign sw_done = sw_reset_busy && sw_cnt_r == SW_CNT_LAST;
  assign load_defaults = strap_cap || sw_done;

  // ********************************************
  // basic control
  // ********************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {ctl_loopback, ctl_speed100, ctl_an_enable, ctl_power_down} <= 4'h0;
      {ctl_isolate, ctl_restart_an, ctl_full_duplex, ctl_col_test} <= 4'h0;
      an_cmp_d_r <= 1'b0;
    end else begin
      an_cmp_d_r <= stat_an_complete;
      if (load_defaults) begin
        {ctl_loopback, ctl_power_down, ctl_isolate, ctl_restart_an, ctl_col_test} <= 5'h00;
        ctl_speed100 <= st_speed_r;
        ctl_an_enable <= st_an_en_r;
        ctl_full_duplex <= st_duplex_r;
        if (strap_cap) begin
          ctl_speed100 <= strap_s[1];
          ctl_an_enable <= strap_s[2];
          ctl_full_duplex <= strap_s[0];
        end
      end else if (bc_wr && !sw_reset_busy) begin
        ctl_loopback <= bus.wdata[BC_LOOPBACK];
        ctl_speed100 <= bus.wdata[BC_SPEED];
        ctl_an_enable <= bus.wdata[BC_AN_ENABLE];
        ctl_power_down <= bus.wdata[BC_POWER_DOWN];
        ctl_isolate <= bus.wdata[BC_ISOLATE];
        ctl_restart_an <= bus.wdata[BC_RESTART_AN] | (ctl_restart_an & ~(stat_an_complete & ~an_cmp_d_r));
        ctl_full_duplex <= bus.wdata[BC_DUPLEX];
        ctl_col_test <= bus.wdata[BC_COL_TEST];
      end else if (stat_an_complete && !an_cmp_d_r) begin
        ctl_restart_an <= 1'b0;
      end
    end
  end

  // ********************************************
  // advertisement, next page and extended storage
  // ********************************************
  always_comb begin
    ext_hit = 1'b1;
    ext_idx = 3'h0;
    case (bus.addr)
      ADDR_CODING_SUBLAYER_CONFIG: ext_idx = 3'h0;
      ADDR_REDUCED_IF_BYPASS: ext_idx = 3'h1;
      ADDR_LED_DIRECT_CONTROL: ext_idx = 3'h2;
      ADDR_PHY_CONTROL: ext_idx = 3'h3;
      ADDR_TEN_BASE_STATUS_CONTROL: ext_idx = 3'h4;
      ADDR_TEST_AND_SELFTEST_EXT: ext_idx = 3'h5;
      ADDR_ENERGY_DETECT_CONTROL: ext_idx = 3'h6;
      default: ext_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      adv_word <= ADV_RESET;
      np_tx_word <= NP_TX_RESET;
      for (int i = 0; i < EXT_RW_NUM; i++) begin
        ext_r[i] <= EXT_RESET;
      end
    end else if (load_defaults) begin
      adv_word <= ADV_RESET;
      np_tx_word <= NP_TX_RESET;
      for (int i = 0; i < EXT_RW_NUM; i++) begin
        ext_r[i] <= EXT_RESET;
      end
    end else if (wr_ok && !sw_reset_busy) begin
      if (bus.addr == ADDR_AUTONEG_ADVERTISE) begin
        adv_word <= bus.wdata & 16'hAFFF; // bits 14 and 12 reserved
      end
      if (bus.addr == ADDR_NEXT_PAGE_TRANSMIT) begin
        np_tx_word <= bus.wdata & 16'hBFFF;
      end
      if (ext_hit) begin
        ext_r[ext_idx] <= bus.wdata;
      end
    end
  end

  // ********************************************
  // latched status and event counters
  // ********************************************
  assign rd_of_status = rd_ok && bus.addr == ADDR_BASIC_STATUS;
  assign rd_of_expansion = rd_ok && bus.addr == ADDR_AUTONEG_EXPANSION;
  assign rd_of_summary = rd_ok && bus.addr == ADDR_PHY_SUMMARY_STATUS;
  assign rd_of_fc = rd_ok && bus.addr == ADDR_FALSE_CARRIER_COUNTER;
  assign rd_of_rxe = rd_ok && bus.addr == ADDR_RECEIVE_ERROR_COUNTER;

  // link latches low until read; faults latch high until read; a new event beats the read
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      link_ll_r <= 1'b0;
      rf_lh_r <= 1'b0;
      jab_lh_r <= 1'b0;
      page_rx_r <= 1'b0;
      fc_latch_r <= 1'b0;
      rxe_latch_r <= 1'b0;
    end else if (load_defaults) begin
      link_ll_r <= stat_link_up;
      rf_lh_r <= stat_remote_fault;
      jab_lh_r <= stat_jabber;
      page_rx_r <= stat_page_rx;
      fc_latch_r <= false_carrier_evt;
      rxe_latch_r <= rx_error_evt;
    end else begin
      link_ll_r <= stat_link_up & (link_ll_r | rd_of_status);
      rf_lh_r <= stat_remote_fault | (rf_lh_r & ~rd_of_status);
      jab_lh_r <= stat_jabber | (jab_lh_r & ~rd_of_status);
      page_rx_r <= stat_page_rx | (page_rx_r & ~(rd_of_expansion | rd_of_summary));
      fc_latch_r <= false_carrier_evt | (fc_latch_r & ~rd_of_summary);
      rxe_latch_r <= rx_error_evt | (rxe_latch_r & ~rd_of_summary);
    end
  end

  // saturating counters, cleared on read; an event in the read cycle counts as one
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fc_cnt_r <= '0;
      rxe_cnt_r <= '0;
    end else if (load_defaults) begin
      fc_cnt_r <= '0;
      rxe_cnt_r <= '0;
    end else begin
      if (rd_of_fc) begin
        fc_cnt_r <= CNT_W'(false_carrier_evt);
      end else if (false_carrier_evt && fc_cnt_r != CNT_MAX) begin
        fc_cnt_r <= fc_cnt_r + CNT_W'(1);
      end
      if (rd_of_rxe) begin
        rxe_cnt_r <= CNT_W'(rx_error_evt);
      end else if (rx_error_evt && rxe_cnt_r != CNT_MAX) begin
        rxe_cnt_r <= rxe_cnt_r + CNT_W'(1);
      end
    end
  end

  // ********************************************
  // read multiplexer
  // ********************************************
  always_comb begin
    rdata_nxt = 16'h0000;
    case (bus.addr)
      ADDR_BASIC_CONTROL: begin
        rdata_nxt = {sw_reset_busy, ctl_loopback, ctl_speed100, ctl_an_enable, ctl_power_down,
                     ctl_isolate, ctl_restart_an, ctl_full_duplex, ctl_col_test, 7'h00};
      end
      ADDR_BASIC_STATUS: begin
        rdata_nxt = {BS_ABILITIES, 4'h0, 1'b1, stat_an_complete, rf_lh_r, 1'b1,
                     link_ll_r, jab_lh_r, 1'b1};
      end
      ADDR_IDENTIFIER_HIGH: rdata_nxt = OUI_VALUE[21:6];
      ADDR_IDENTIFIER_LOW: rdata_nxt = {OUI_VALUE[5:0], MODEL_NUMBER, MODEL_REVISION};
      ADDR_AUTONEG_ADVERTISE: rdata_nxt = adv_word;
      ADDR_PARTNER_ABILITY: begin
        rdata_nxt = stat_next_page_sel ? lp_next_page : (lp_base_page & 16'hEFFF);
      end
      ADDR_AUTONEG_EXPANSION: begin
        rdata_nxt = {11'h000, 1'b0, stat_lp_np_able, 1'b1, page_rx_r, stat_lp_an_able};
      end
      ADDR_NEXT_PAGE_TRANSMIT: rdata_nxt = np_tx_word;
      ADDR_PHY_SUMMARY_STATUS: begin
        rdata_nxt = {1'b0, stat_mdix, rxe_latch_r, stat_polarity, fc_latch_r, 2'h0, page_rx_r,
                     1'b0, rf_lh_r, jab_lh_r, stat_an_complete, ctl_loopback, ctl_full_duplex,
                     stat_speed10, stat_link_up};
      end
      ADDR_FALSE_CARRIER_COUNTER: rdata_nxt = {8'h00, fc_cnt_r};
      ADDR_RECEIVE_ERROR_COUNTER: rdata_nxt = {8'h00, rxe_cnt_r};
      ADDR_PHY_CONTROL: rdata_nxt = {ext_r[3][15:PHYCTL_ADDR_W], phy_addr};
      default: begin
        if (ext_hit) begin
          rdata_nxt = ext_r[ext_idx];
        end
      end
    endcase
  end
  assign bus.rdata = rdata_nxt;

  // ********************************************
  // serial management engine
  // ********************************************
  phyrm_mdio u_mdio (
    .clk(clk),
    .resetn(resetn),
    .mdc(mdc),
    .mdio_i(mdio_i),
    .mdio_o(mdio_o),
    .mdio_oe_n(mdio_oe_n),
    .phy_addr(phy_addr),
    .bus(bus)
  );
endmodule

/* File: verif/phyrm_station.sv */
// management station model: bit-banged frames on mdc and mdio
`timescale 1ns/1ps
module phyrm_station (
  input wire logic clk,
  input wire logic mdio,
  output logic mdc = 1'b0,
  output logic md = 1'b1,
  output logic md_oe = 1'b0
);
  // one frame, 8 clk per mdc period; line released for turnaround and read data
  task automatic frame(input logic r, input logic [9:0] ar, input logic [15:0] wd, output logic [15:0] q);
    logic [32:0] w;
    w = {3'b101, r ? 2'h2 : 2'h1, ar, 2'h2, wd};
    for (int i = 32; i >= 0; i--) begin
      md_oe = !(r && i < 18);
      md = w[i];
      repeat (4) @(posedge clk);
      #1 mdc = 1'b1;
      if (i < 16) q[i] = mdio; // data bit still standing at this rise
      repeat (4) @(posedge clk);
      #1 mdc = 1'b0;
    end
    md_oe = 1'b0;
  endtask
endmodule

/* File: verif/phyrm_top_properties.sv */
// assertions on the register bank top ports
`timescale 1ns/1ps
module phyrm_top_chk
  import phyrm_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [4:0] strap_phy_addr,
  input wire logic ctl_loopback,
  input wire logic [15:0] adv_word,
  input wire logic [4:0] phy_addr,
  input wire logic sw_reset_busy,
  input wire logic dev_ready
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // software reset steps: busy near fifty cycles, then defaults back
  sequence busy_run;
    sw_reset_busy [*8] ##41 sw_reset_busy;
  endsequence
  sequence dflt_back;
    ##[0:1] (adv_word == ADV_RESET && !ctl_loopback);
  endsequence
  por_ready_a: assert property (!dev_ready |-> ##[1:6] dev_ready) else $error("late ready");
  ready_hold_a: assert property (dev_ready |=> dev_ready) else $error("ready lost");
  strap_take_a: assert property ($rose(dev_ready) |-> phy_addr == strap_phy_addr) else $error("strap");
  hw_dflt_a: assert property ($rose(dev_ready) |-> dflt_back) else $error("hw dflt");
  busy_len_a: assert property ($rose(sw_reset_busy) |-> busy_run ##[1:3] !sw_reset_busy) else $error("len");
  sw_dflt_a: assert property ($fell(sw_reset_busy) |-> dflt_back) else $error("sw dflt");
  strap_kept_a: assert property (sw_reset_busy |=> $stable(phy_addr)) else $error("addr");
  busy_ready_a: assert property (sw_reset_busy |-> dev_ready) else $error("busy");
endmodule
bind phyrm_top phyrm_top_chk u_chk (.clk(clk), .resetn(resetn), .strap_phy_addr(strap_phy_addr),
  .ctl_loopback(ctl_loopback), .adv_word(adv_word), .phy_addr(phy_addr), .sw_reset_busy(sw_reset_busy),
  .dev_ready(dev_ready));

/* File: verif/test_phy_reset_and_mgmt_register_map.sv */
// bench: station frames exercise resets and the register map
`timescale 1ns/1ps
module test_phy_reset_and_mgmt_register_map;
  import phyrm_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, mdc, md, md_oe, mo, mo_n, busy, rdy;
  logic [7:0] sp = 8'hF7, ctl; // straps {addr 1E, an, speed100, duplex}
  logic [12:0] s = 13'h0001; // status inputs, bit 0 link up
  logic [15:0] lpb = 16'hFFFF, lpn = 16'h2ABC, adv, np, q;
  logic [4:0] pa, adr = 5'h1E;
  int miscompares = 0, samples_checked = 0;
  wire mw = !mo_n ? mo : (md_oe ? md : 1'b1); // released line pulled up
  initial forever #10 clk = ~clk;
  phyrm_station st (.clk(clk), .mdio(mw), .mdc(mdc), .md(md), .md_oe(md_oe));
  phyrm_top dut (.clk(clk), .resetn(resetn), .mdc(mdc), .mdio_i(mw), .mdio_o(mo), .mdio_oe_n(mo_n),
    .strap_phy_addr(sp[7:3]), .strap_an_enable(sp[2]), .strap_speed100(sp[1]), .strap_full_duplex(sp[0]),
    .stat_link_up(s[0]), .stat_an_complete(s[1]), .stat_next_page_sel(s[2]), .stat_remote_fault(s[3]),
    .stat_jabber(s[4]), .stat_page_rx(s[5]), .stat_lp_np_able(s[6]), .stat_lp_an_able(s[7]), .stat_speed10(s[8]),
    .stat_mdix(s[9]), .stat_polarity(s[10]), .false_carrier_evt(s[11]), .rx_error_evt(s[12]), .lp_base_page(lpb),
    .lp_next_page(lpn), .ctl_loopback(ctl[7]), .ctl_speed100(ctl[6]), .ctl_an_enable(ctl[5]),
    .ctl_power_down(ctl[4]), .ctl_isolate(ctl[3]), .ctl_restart_an(ctl[2]), .ctl_full_duplex(ctl[1]),
    .ctl_col_test(ctl[0]), .adv_word(adv), .np_tx_word(np), .phy_addr(pa), .sw_reset_busy(busy), .dev_ready(rdy));
  // wait edges, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  // r=1 reads and compares with d, r=0 writes d
  task automatic rw(input logic r, input logic [4:0] a, input logic [15:0] d);
    st.frame(r, {adr, a}, d, q);
    tick(4);
    if (r) chk($sformatf("reg %h", a), d, q);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    stop_test();
  end
  // main sequence
  initial begin
    tick(3);
    resetn = 1'b1;
    tick(10);
    chk("ready", 16'h1, {15'h0, rdy});
    rw(1, 5'h00, 16'h3100);
    rw(1, 5'h02, 16'h2969);
    rw(1, 5'h03, 16'h6951);
    rw(1, 5'h07, 16'h2001);
    chk("np", NP_TX_RESET, np);
    rw(1, 5'h06, 16'h0004);
    rw(1, 5'h08, 16'h0000);
    $display("test defaults done");
    st.frame(1, {adr, 5'h01}, 16'h0000, q);
    s[0] = 1'b0;
    tick(1);
    s[0] = 1'b1;
    rw(1, 5'h01, {BS_ABILITIES, 11'h049});
    rw(0, 5'h01, 16'h0000);
    rw(1, 5'h01, {BS_ABILITIES, 11'h04D});
    rw(1, 5'h05, 16'hEFFF);
    s[2] = 1'b1;
    rw(1, 5'h05, 16'h2ABC);
    rw(0, 5'h00, 16'h42FF);
    chk("ctl", 16'h0085, {8'h00, ctl});
    rw(1, 5'h00, 16'h4280);
    rw(0, 5'h04, 16'h0DE1);
    chk("adv", 16'h0DE1, adv);
    rw(0, 5'h07, 16'hFFFF);
    chk("np", 16'hBFFF, np);
    rw(0, 5'h19, 16'hFFFF);
    rw(1, 5'h19, 16'hFFFE);
    s[11] = 1'b1;
    tick(3);
    s[11] = 1'b0;
    rw(1, 5'h14, 16'h0003);
    rw(1, 5'h14, 16'h0000);
    $display("test access done");
    sp = 8'h48;
    rw(0, 5'h00, 16'h8000);
    chk("busy", 16'h1, {15'h0, busy});
    tick(MDIO_QUIET_CYC);
    chk("busy", 16'h0, {15'h0, busy});
    rw(1, 5'h00, 16'h3100);
    rw(1, 5'h04, ADV_RESET);
    chk("addr", 16'h001E, {11'h0, pa});
    chk("np", NP_TX_RESET, np);
    rw(1, 5'h19, 16'h001E);
    $display("test soft reset done");
    resetn = 1'b0;
    tick(HW_RESET_MIN_CYC);
    resetn = 1'b1;
    tick(10);
    adr = 5'h09;
    chk("addr", 16'h0009, {11'h0, pa});
    rw(1, 5'h00, 16'h0000);
    $display("test hard reset done");
    stop_test();
  end
endmodule
